// file: design/card_host_regs.vh
`ifndef CARD_HOST_REGS_VH
`define CARD_HOST_REGS_VH

// Configuration indexes
`define CFG_MEM_MAPPED 2'h0
`define CFG_CONTIG_IO 2'h1
`define CFG_PRIMARY_IO 2'h2
`define CFG_SECONDARY_IO 2'h3

// Task file offsets
`define OFS_DATA 4'h0
`define OFS_FAULT 4'h1
`define OFS_COUNT 4'h2
`define OFS_START 4'h3
`define OFS_TRK_LO 4'h4
`define OFS_TRK_HI 4'h5
`define OFS_UNIT 4'h6
`define OFS_STATE 4'h7
`define OFS_DUP_EVEN 4'h8
`define OFS_DUP_ODD 4'h9
`define OFS_DUP_FAULT 4'hd
`define OFS_SHADOW 4'he
`define OFS_UNIT_ADDR 4'hf

// Primary and secondary block bases, A9..A4
`define PRI_CMD_BASE 6'h1f
`define PRI_CTL_BASE 6'h3f
`define SEC_CMD_BASE 6'h17
`define SEC_CTL_BASE 6'h37
`define CTL_OFS_LO 3'h6

// Memory window select bit and reset values
`define MEM_WIN_BIT 10
`define IRQ_DEFAULT 4'he
`define STATE_RESET 8'h50
`define UNIT_RESET 8'ha0
`define LANE_IDLE 8'h00

`endif

// file: design/sector_fifo.v
`timescale 1ns/1ps
module sector_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH_LOG2 = 8
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire push_i,
	input wire [WIDTH-1:0] push_data_i,
	input wire pop_i,
	output wire [WIDTH-1:0] pop_data_o,
	output wire empty_o,
	output wire full_o
);
	reg [WIDTH-1:0] mem_r [0:(1<<DEPTH_LOG2)-1];
	reg [DEPTH_LOG2:0] wr_ptr_r;
	reg [DEPTH_LOG2:0] rd_ptr_r;

	assign empty_o = (wr_ptr_r == rd_ptr_r);
	assign full_o = (wr_ptr_r[DEPTH_LOG2-1:0] == rd_ptr_r[DEPTH_LOG2-1:0]) &&
		(wr_ptr_r[DEPTH_LOG2] != rd_ptr_r[DEPTH_LOG2]);
	assign pop_data_o = mem_r[rd_ptr_r[DEPTH_LOG2-1:0]];

	always @(posedge clk_sys_i)
	begin
		if (push_i && !full_o)
			mem_r[wr_ptr_r[DEPTH_LOG2-1:0]] <= push_data_i;
	end

	// Sequential pointers only: the data port is a stream, not a window
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			wr_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
			rd_ptr_r <= {(DEPTH_LOG2+1){1'b0}};
		end
		else
		begin
			if (push_i && !full_o)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (pop_i && !empty_o)
				rd_ptr_r <= rd_ptr_r + 1'b1;
		end
	end
endmodule

// file: design/card_host_bus_access_decoder.v
// Summary of operation
// - Drive 16-bit indicator for 16-bit capable ports
// - Every decoded I/O address is 16-bit capable
// - Byte read drives low lane only, save CE2-only in socket mode
// - Word read drives odd high, even low
// - CE2-only read in socket mode moves odd byte high
// - Common memory uses same lane steering
// - Grounded output enable at power-up: native
// - Native mode: only task file I/O
// - Native mode ignores memory accesses
// - Reinsertion returns card to socket mode
// - Four mapping methods by configuration index
// - Index 1: sixteen contiguous registers
// - Index 2: primary ranges, drive number
// - Index 3: secondary ranges, drive number
// - Primary interrupt line defaults to 14
// - Command block and control offsets mapping
// - Both enables low: data word access
// - Byte pairs: even byte then odd
// - CE2-only byte at 0: fault/option
// - Data port streams through sector FIFO
`timescale 1ns/1ps
`include "card_host_regs.vh"
module card_host_bus_access_decoder #(
	parameter FIFO_DEPTH_LOG2 = 8
) (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire power_good_i,
	input wire card_inserted_i,
	input wire reg_n_i,
	input wire ce1_n_i,
	input wire ce2_n_i,
	input wire [10:0] addr_i,
	input wire iord_n_i,
	input wire iowr_n_i,
	input wire oe_n_i,
	input wire we_n_i,
	input wire [15:0] data_i,
	input wire [1:0] config_index_i,
	input wire drive_number_i,
	input wire [3:0] irq_select_i,
	input wire [7:0] error_code_i,
	input wire [15:0] fill_data_i,
	input wire fill_valid_i,
	input wire drain_i,
	output reg [15:0] data_o,
	output reg data_hi_oe_o,
	output reg data_lo_oe_o,
	output reg iois16_n_o,
	output reg native_disk_mode_o,
	output reg [3:0] irq_line_o,
	output reg [15:0] drain_data_o,
	output reg drain_valid_o,
	output reg [7:0] opcode_o,
	output reg opcode_stb_o,
	output reg [7:0] option_byte_o,
	output reg [7:0] control_o
);
	reg [7:0] count_r;
	reg [7:0] start_r;
	reg [7:0] trk_lo_r;
	reg [7:0] trk_hi_r;
	reg [7:0] unit_r;
	reg [7:0] state_r;
	reg power_prev_r;
	reg ins_prev_r;
	reg odd_pending_r;
	reg [7:0] rd_even_hold_r;
	reg [7:0] wr_even_hold_r;
	reg strobe_prev_r;
	reg iord_n_prev_r;
	reg [3:0] ofs_prev_r;
	reg wide_prev_r;
	reg even_prev_r;

	wire rd_fifo_pop;
	wire [15:0] rd_fifo_data;
	wire rd_fifo_empty;
	wire wr_fifo_empty;
	wire [15:0] wr_fifo_data;
	reg wr_push;
	reg [15:0] wr_word;
	reg rd_pop;

	// Decoded access
	reg hit;
	reg [3:0] ofs;
	reg io_cycle;
	reg mem_cycle;
	reg rd_act;
	reg wr_act;
	wire word_acc = !ce1_n_i && !ce2_n_i;
	wire even_only = !ce1_n_i && ce2_n_i;
	wire odd_only = ce1_n_i && !ce2_n_i;

	function [7:0] task_read;
		input [3:0] o;
		begin
			case (o)
				`OFS_FAULT, `OFS_DUP_FAULT: task_read = error_code_i;
				`OFS_COUNT: task_read = count_r;
				`OFS_START: task_read = start_r;
				`OFS_TRK_LO: task_read = trk_lo_r;
				`OFS_TRK_HI: task_read = trk_hi_r;
				`OFS_UNIT: task_read = unit_r;
				`OFS_STATE, `OFS_SHADOW: task_read = state_r;
				`OFS_UNIT_ADDR: task_read = {1'b1, ~unit_r[4], ~unit_r[4], 5'h1f};
				default: task_read = `LANE_IDLE;
			endcase
		end
	endfunction

	always @*
	begin
		io_cycle = !reg_n_i && (!iord_n_i || !iowr_n_i);
		mem_cycle = reg_n_i && (!oe_n_i || !we_n_i) && !native_disk_mode_o;
		hit = 1'b0;
		ofs = addr_i[3:0];
		if (native_disk_mode_o)
		begin
			if (even_only && (!iord_n_i || !iowr_n_i))
			begin
				hit = 1'b1;
				ofs = {1'b0, addr_i[2:0]};
			end
			else if (odd_only && addr_i[2:0] == `CTL_OFS_LO && (!iord_n_i || !iowr_n_i))
			begin
				hit = 1'b1;
				ofs = `OFS_SHADOW;
			end
		end
		else if (!(ce1_n_i && ce2_n_i))
		begin
			case (config_index_i)
				`CFG_MEM_MAPPED:
				begin
					if (mem_cycle)
					begin
						hit = 1'b1;
						if (addr_i[`MEM_WIN_BIT])
							ofs = addr_i[0] ? `OFS_DUP_ODD : `OFS_DUP_EVEN;
					end
				end
				`CFG_CONTIG_IO:
					hit = io_cycle;
				`CFG_PRIMARY_IO, `CFG_SECONDARY_IO:
				begin
					if (io_cycle && addr_i[3] == 1'b0)
					begin
						if (addr_i[9:4] == ((config_index_i == `CFG_PRIMARY_IO) ? `PRI_CMD_BASE : `SEC_CMD_BASE))
							hit = 1'b1;
						else if (addr_i[9:4] == ((config_index_i == `CFG_PRIMARY_IO) ? `PRI_CTL_BASE : `SEC_CTL_BASE)
							&& addr_i[2:1] == 2'h3)
						begin
							hit = 1'b1;
							ofs = {2'h3, addr_i[1:0]};
						end
					end
				end
				default: hit = 1'b0;
			endcase
		end
		rd_act = hit && (io_cycle ? !iord_n_i : !oe_n_i);
		wr_act = hit && (io_cycle ? !iowr_n_i : !we_n_i);
	end

	function is_data_ofs;
		input [3:0] o;
		is_data_ofs = (o == `OFS_DATA) || (o == `OFS_DUP_EVEN) || (o == `OFS_DUP_ODD);
	endfunction
	// Strobe-end FIFO moves use the decode latched during the strobe, as the host drops the enables with it
	wire data_ofs = is_data_ofs(ofs);
	wire data_ofs_prev = is_data_ofs(ofs_prev_r);
	wire strobe_now = rd_act || wr_act;
	wire strobe_start = strobe_now && !strobe_prev_r;
	wire strobe_end = !strobe_now && strobe_prev_r;

	// Byte steering of a read, and FIFO pop/push at strobe end
	reg [15:0] rd_word;
	reg hi_drive;
	reg lo_drive;
	always @*
	begin
		rd_word = {8'h00, `LANE_IDLE};
		hi_drive = 1'b0;
		lo_drive = 1'b0;
		rd_pop = 1'b0;
		wr_push = 1'b0;
		wr_word = data_i;
		if (rd_act)
		begin
			if (word_acc && data_ofs)
			begin
				rd_word = rd_fifo_data;
				hi_drive = 1'b1;
				lo_drive = 1'b1;
			end
			else if (word_acc)
			begin
				rd_word = {task_read(ofs | 4'h1), task_read(ofs & 4'he)};
				hi_drive = 1'b1;
				lo_drive = 1'b1;
			end
			else if (odd_only && !native_disk_mode_o)
			begin
				hi_drive = 1'b1;
				if (ofs == `OFS_DATA)
					rd_word[15:8] = error_code_i;
				else if (data_ofs)
					rd_word[15:8] = rd_fifo_data[15:8];
				else
					rd_word[15:8] = task_read(ofs | 4'h1);
			end
			else
			begin
				lo_drive = 1'b1;
				if (ofs == `OFS_DUP_ODD && !odd_pending_r)
					rd_word[7:0] = rd_fifo_data[15:8];
				else if (data_ofs)
					rd_word[7:0] = odd_pending_r ? rd_even_hold_r : rd_fifo_data[7:0];
				else
					rd_word[7:0] = task_read(ofs);
			end
		end
		if (strobe_end && data_ofs_prev)
		begin
			if (!iord_n_prev_r)
				rd_pop = even_prev_r ? !odd_pending_r : (wide_prev_r || ofs_prev_r != `OFS_DATA);
			else
			begin
				wr_push = even_prev_r ? (odd_pending_r || ofs_prev_r == `OFS_DUP_ODD)
					: (wide_prev_r || ofs_prev_r != `OFS_DATA);
				if (wide_prev_r)
					wr_word = data_i;
				else if (even_prev_r)
					wr_word = {data_i[7:0], wr_even_hold_r};
				else
					wr_word = {data_i[15:8], wr_even_hold_r};
			end
		end
	end

	sector_fifo #(
		.WIDTH(16),
		.DEPTH_LOG2(FIFO_DEPTH_LOG2)
	) u_read_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.push_i(fill_valid_i),
		.push_data_i(fill_data_i),
		.pop_i(rd_fifo_pop),
		.pop_data_o(rd_fifo_data),
		.empty_o(rd_fifo_empty),
		.full_o()
	);

	sector_fifo #(
		.WIDTH(16),
		.DEPTH_LOG2(FIFO_DEPTH_LOG2)
	) u_write_fifo (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.push_i(wr_push),
		.push_data_i(wr_word),
		.pop_i(drain_i),
		.pop_data_o(wr_fifo_data),
		.empty_o(wr_fifo_empty),
		.full_o()
	);

	assign rd_fifo_pop = rd_pop;

	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			data_o <= 16'h0000;
			data_hi_oe_o <= 1'b0;
			data_lo_oe_o <= 1'b0;
			iois16_n_o <= 1'b1;
			native_disk_mode_o <= 1'b0;
			irq_line_o <= `IRQ_DEFAULT;
			drain_data_o <= 16'h0000;
			drain_valid_o <= 1'b0;
			opcode_o <= 8'h00;
			opcode_stb_o <= 1'b0;
			option_byte_o <= 8'h00;
			control_o <= 8'h00;
			count_r <= 8'h01;
			start_r <= 8'h01;
			trk_lo_r <= 8'h00;
			trk_hi_r <= 8'h00;
			unit_r <= `UNIT_RESET;
			state_r <= `STATE_RESET;
			power_prev_r <= 1'b0;
			ins_prev_r <= 1'b0;
			odd_pending_r <= 1'b0;
			rd_even_hold_r <= 8'h00;
			wr_even_hold_r <= 8'h00;
			strobe_prev_r <= 1'b0;
			iord_n_prev_r <= 1'b1;
			ofs_prev_r <= 4'h0;
			wide_prev_r <= 1'b0;
			even_prev_r <= 1'b0;
		end
		else
		begin
			power_prev_r <= power_good_i;
			ins_prev_r <= card_inserted_i;
			// Mode is sampled once on the power-up edge, so later toggling of OE is a normal strobe
			if (power_good_i && !power_prev_r)
				native_disk_mode_o <= !oe_n_i;
			else if (card_inserted_i && !ins_prev_r && power_prev_r)
				native_disk_mode_o <= 1'b0;
			irq_line_o <= (config_index_i == `CFG_PRIMARY_IO && irq_select_i == 4'h0) ? `IRQ_DEFAULT : irq_select_i;
			iois16_n_o <= !(hit && !reg_n_i);
			data_o <= rd_word;
			data_hi_oe_o <= hi_drive;
			data_lo_oe_o <= lo_drive;
			strobe_prev_r <= strobe_now;
			if (strobe_now)
			begin
				iord_n_prev_r <= !rd_act;
				ofs_prev_r <= ofs;
				wide_prev_r <= word_acc;
				even_prev_r <= even_only;
			end
			drain_data_o <= wr_fifo_data;
			drain_valid_o <= !wr_fifo_empty;
			opcode_stb_o <= 1'b0;
			if (strobe_end && data_ofs_prev && even_prev_r && (ofs_prev_r != `OFS_DUP_ODD || odd_pending_r))
			begin
				odd_pending_r <= !odd_pending_r;
				if (iord_n_prev_r)
					wr_even_hold_r <= data_i[7:0];
				else if (!odd_pending_r)
					rd_even_hold_r <= rd_fifo_data[15:8];
			end
			if (strobe_start && wr_act && !(data_ofs && !odd_only))
			begin
				case ((odd_only && !native_disk_mode_o) ? (ofs | 4'h1) : ofs)
					`OFS_DATA, `OFS_FAULT, `OFS_DUP_FAULT: option_byte_o <= odd_only ? data_i[15:8] : data_i[7:0];
					`OFS_COUNT: count_r <= data_i[7:0];
					`OFS_START: start_r <= data_i[7:0];
					`OFS_TRK_LO: trk_lo_r <= data_i[7:0];
					`OFS_TRK_HI: trk_hi_r <= data_i[7:0];
					`OFS_UNIT: unit_r <= {data_i[7:5], drive_number_i, data_i[3:0]};
					`OFS_STATE:
					begin
						opcode_o <= data_i[7:0];
						opcode_stb_o <= 1'b1;
					end
					`OFS_SHADOW: control_o <= data_i[7:0];
					default: opcode_stb_o <= 1'b0;
				endcase
			end
			state_r <= {state_r[7], state_r[6], state_r[5], state_r[4], !rd_fifo_empty, state_r[2:0]};
		end
	end
endmodule

// file: bench/card_host_checker_asserts.sv
`timescale 1ns/1ps
module card_host_checker (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire reg_n_i,
	input wire ce1_n_i,
	input wire ce2_n_i,
	input wire [10:0] addr_i,
	input wire iord_n_i,
	input wire iowr_n_i,
	input wire oe_n_i,
	input wire [1:0] config_index_i,
	input wire [3:0] irq_select_i,
	input wire data_hi_oe_o,
	input wire data_lo_oe_o,
	input wire iois16_n_o,
	input wire native_disk_mode_o,
	input wire [3:0] irq_line_o,
	input wire opcode_stb_o
);
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!rst_n_i);
	// Three-cycle windows skip the one cycle that outputs stand after a strobe ends
	a_standby_lanes_off: assert property ((ce1_n_i && ce2_n_i) [*3] |-> !data_hi_oe_o && !data_lo_oe_o)
		else $error("lanes driven in standby");
	a_byte_low_only: assert property ((!native_disk_mode_o && !ce1_n_i && ce2_n_i) [*3] |-> !data_hi_oe_o)
		else $error("high lane driven on even byte access");
	a_odd_high_only: assert property ((!native_disk_mode_o && ce1_n_i && !ce2_n_i) [*3] |-> !data_lo_oe_o)
		else $error("low lane driven on odd byte access");
	a_mem_word_lanes: assert property ((!native_disk_mode_o && reg_n_i && !ce1_n_i && !ce2_n_i && !oe_n_i
		&& config_index_i == 2'h0 && addr_i == 11'h000) [*3] |-> data_hi_oe_o && data_lo_oe_o)
		else $error("memory word read not on both lanes");
	a_native_no_mem: assert property ((native_disk_mode_o && reg_n_i && !oe_n_i && iord_n_i) [*3]
		|-> !data_hi_oe_o && !data_lo_oe_o)
		else $error("memory read answered in native mode");
	a_native_both_ce: assert property ((native_disk_mode_o && !ce1_n_i && !ce2_n_i) [*3]
		|-> !data_hi_oe_o && !data_lo_oe_o)
		else $error("invalid enables drove lanes");
	a_wide_port_cause: assert property (!iois16_n_o |-> $past(!iord_n_i || !iowr_n_i)
		|| $past(!iord_n_i || !iowr_n_i, 2))
		else $error("wide port indicator without I/O strobe");
	a_opcode_one_cycle: assert property (opcode_stb_o |=> !opcode_stb_o)
		else $error("opcode strobe longer than one cycle");
	a_primary_irq_default: assert property ((config_index_i == 2'h2 && irq_select_i == 4'h0) [*3]
		|-> irq_line_o == 4'he)
		else $error("default interrupt line not 14");
endmodule
bind card_host_bus_access_decoder card_host_checker card_host_checker_inst (.clk_sys_i, .rst_n_i, .reg_n_i,
	.ce1_n_i, .ce2_n_i, .addr_i, .iord_n_i, .iowr_n_i, .oe_n_i, .config_index_i, .irq_select_i, .data_hi_oe_o,
	.data_lo_oe_o, .iois16_n_o, .native_disk_mode_o, .irq_line_o, .opcode_stb_o);

// file: bench/media_side_model.sv
`timescale 1ns/1ps
module media_side_model (
	input wire clk_sys_i,
	input wire rst_n_i,
	input wire push_i,
	input wire [15:0] push_word_i,
	input wire drain_valid_i,
	input wire [15:0] drain_data_i,
	output reg [15:0] fill_data_o,
	output reg fill_valid_o,
	output reg drain_o,
	output reg [15:0] last_word_o
);
	reg [1:0] wait_r;
	always @(posedge clk_sys_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			fill_data_o <= 16'h0000;
			fill_valid_o <= 1'b0;
			drain_o <= 1'b0;
			last_word_o <= 16'h0000;
			wait_r <= 2'h0;
		end
		else
		begin
			fill_valid_o <= push_i;
			// Idle data toggles so a stale word is never taken for a fresh one
			fill_data_o <= push_i ? push_word_i : ~fill_data_o;
			drain_o <= 1'b0;
			// Stalls three cycles before taking each word, a slow buffer side
			wait_r <= drain_valid_i ? wait_r + 2'h1 : 2'h0;
			if (drain_valid_i && &wait_r && !drain_o)
			begin
				drain_o <= 1'b1;
				last_word_o <= drain_data_i;
			end
		end
	end
endmodule

// file: bench/card_host_bus_access_decoder_tb.sv
`timescale 1ns/1ps
module card_host_bus_access_decoder_tb;
	reg clk_sys_i;
	reg rst_n_i = 1'b0;
	reg power_good_i = 1'b0;
	reg card_inserted_i = 1'b1;
	reg reg_n_i = 1'b1, ce1_n_i = 1'b1, ce2_n_i = 1'b1, iord_n_i = 1'b1, iowr_n_i = 1'b1, oe_n_i = 1'b1, we_n_i = 1'b1;
	reg [10:0] addr_i = 11'h000;
	reg [15:0] data_i = 16'h0000, push_word = 16'h0000, rdat;
	reg [1:0] config_index_i = 2'h2, lanes;
	reg [3:0] irq_select_i = 4'h0;
	reg push = 1'b0, io16;
	wire [15:0] data_o, drain_data_o, fill_data, last_word;
	wire [7:0] opcode_o, option_byte_o, control_o;
	wire [3:0] irq_line_o;
	wire data_hi_oe_o, data_lo_oe_o, iois16_n_o, native_disk_mode_o, drain_valid_o, opcode_stb_o, fill_valid, drain;
	integer err_total = 0, total_checks = 0, i;
	card_host_bus_access_decoder #(.FIFO_DEPTH_LOG2(2)) card_host_bus_access_decoder_inst (.clk_sys_i, .rst_n_i,
		.power_good_i, .card_inserted_i, .reg_n_i, .ce1_n_i, .ce2_n_i, .addr_i, .iord_n_i, .iowr_n_i, .oe_n_i,
		.we_n_i, .data_i, .config_index_i, .drive_number_i(1'b0), .irq_select_i, .error_code_i(8'h3c),
		.fill_data_i(fill_data), .fill_valid_i(fill_valid), .drain_i(drain), .data_o, .data_hi_oe_o, .data_lo_oe_o,
		.iois16_n_o, .native_disk_mode_o, .irq_line_o, .drain_data_o, .drain_valid_o, .opcode_o, .opcode_stb_o,
		.option_byte_o, .control_o);
	media_side_model media_side_model_inst (.clk_sys_i, .rst_n_i, .push_i(push), .push_word_i(push_word),
		.drain_valid_i(drain_valid_o), .drain_data_i(drain_data_o), .fill_data_o(fill_data),
		.fill_valid_o(fill_valid), .drain_o(drain), .last_word_o(last_word));
	initial
	begin
		clk_sys_i = 1'b0;
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	task chk(input [15:0] seen, input [15:0] exp);
		begin
			total_checks = total_checks + 1;
			if (seen !== exp)
			begin
				err_total = err_total + 1;
				$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, err_total);
			if (err_total == 0 && total_checks > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	// One strobe held three edges, answer taken after the second, then an idle gap
	task acc(input rd, input mem, input c1, input c2, input [10:0] a, input [15:0] d);
		begin
			@(posedge clk_sys_i) #1;
			reg_n_i = mem;
			{ce1_n_i, ce2_n_i, addr_i, data_i} = {c1, c2, a, d};
			{iord_n_i, iowr_n_i} = {!(rd && !mem), !(!rd && !mem)};
			{oe_n_i, we_n_i} = {!(rd && mem), !(!rd && mem)};
			repeat (2) @(posedge clk_sys_i);
			#1 {rdat, lanes, io16} = {data_o, data_hi_oe_o, data_lo_oe_o, iois16_n_o};
			@(posedge clk_sys_i) #1;
			{iord_n_i, iowr_n_i, oe_n_i, we_n_i, ce1_n_i, ce2_n_i} = 6'h3f;
			repeat (3) @(posedge clk_sys_i);
		end
	endtask
	task rd(input mem, input c1, input c2, input [10:0] a, input [15:0] exp, input [1:0] ln);
		begin
			acc(1'b1, mem, c1, c2, a, 16'h0000);
			chk(lanes, ln);
			chk(rdat & {{8{ln[1]}}, {8{ln[0]}}}, exp);
		end
	endtask
	task fill(input [15:0] w);
		begin
			@(posedge clk_sys_i) #1 push = 1'b1;
			push_word = w;
			@(posedge clk_sys_i) #1 push = 1'b0;
		end
	endtask
	task pwr(input grounded);
		begin
			@(posedge clk_sys_i) #1 power_good_i = 1'b0;
			oe_n_i = !grounded;
			repeat (3) @(posedge clk_sys_i) #1;
			power_good_i = 1'b1;
			repeat (3) @(posedge clk_sys_i) #1;
			oe_n_i = 1'b1;
		end
	endtask
	initial
	begin
		#250000 err_total = err_total + 1;
		finish_test;
	end
	initial
	begin
		repeat (6) @(posedge clk_sys_i);
		#1 rst_n_i = 1'b1;
		chk({iois16_n_o, native_disk_mode_o, data_hi_oe_o, data_lo_oe_o}, 16'h0008);
		chk(irq_line_o, 16'h000e);
		pwr(1'b0);
		chk(native_disk_mode_o, 16'h0000);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h1f2, 16'h005a);
		rd(1'b0, 1'b0, 1'b1, 11'h1f2, 16'h005a, 2'b01);
		chk(io16, 16'h0000);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h1f1, 16'h0077);
		chk(option_byte_o, 16'h0077);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h3f6, 16'h0002);
		chk(control_o, 16'h0002);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h1f7, 16'h00ec);
		chk(opcode_o, 16'h00ec);
		fill(16'h1234);
		fill(16'h5678);
		fill(16'h9abc);
		rd(1'b0, 1'b0, 1'b0, 11'h1f0, 16'h1234, 2'b11);
		rd(1'b0, 1'b0, 1'b1, 11'h1f0, 16'h0078, 2'b01);
		rd(1'b0, 1'b0, 1'b1, 11'h1f0, 16'h0056, 2'b01);
		rd(1'b0, 1'b1, 1'b0, 11'h1f0, 16'h3c00, 2'b10);
		rd(1'b0, 1'b0, 1'b0, 11'h1f0, 16'h9abc, 2'b11);
		rd(1'b0, 1'b0, 1'b1, 11'h100, 16'h0000, 2'b00);
		chk(io16, 16'h0001);
		acc(1'b0, 1'b0, 1'b0, 1'b0, 11'h1f0, 16'hbeef);
		for (i = 0; i < 40 && last_word !== 16'hbeef; i = i + 1)
			@(posedge clk_sys_i);
		chk(last_word, 16'hbeef);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h1f0, 16'h00a1);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h1f0, 16'h00b2);
		for (i = 0; i < 40 && last_word !== 16'hb2a1; i = i + 1)
			@(posedge clk_sys_i);
		chk(last_word, 16'hb2a1);
		config_index_i = 2'h3;
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h172, 16'h0033);
		rd(1'b0, 1'b0, 1'b1, 11'h172, 16'h0033, 2'b01);
		rd(1'b0, 1'b0, 1'b1, 11'h1f2, 16'h0000, 2'b00);
		config_index_i = 2'h1;
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h2a3, 16'h0011);
		rd(1'b0, 1'b0, 1'b1, 11'h5c3, 16'h0011, 2'b01);
		config_index_i = 2'h0;
		acc(1'b0, 1'b1, 1'b0, 1'b1, 11'h004, 16'h0022);
		rd(1'b1, 1'b0, 1'b1, 11'h004, 16'h0022, 2'b01);
		fill(16'hc0de);
		rd(1'b1, 1'b0, 1'b0, 11'h000, 16'hc0de, 2'b11);
		config_index_i = 2'h2;
		irq_select_i = 4'h5;
		repeat (4) @(posedge clk_sys_i) #1;
		chk(irq_line_o, 16'h0005);
		pwr(1'b1);
		chk(native_disk_mode_o, 16'h0001);
		acc(1'b0, 1'b0, 1'b0, 1'b1, 11'h002, 16'h0044);
		rd(1'b0, 1'b0, 1'b1, 11'h002, 16'h0044, 2'b01);
		rd(1'b0, 1'b1, 1'b0, 11'h3f6, 16'h0050, 2'b01);
		rd(1'b1, 1'b0, 1'b1, 11'h004, 16'h0000, 2'b00);
		rd(1'b0, 1'b0, 1'b0, 11'h000, 16'h0000, 2'b00);
		card_inserted_i = 1'b0;
		repeat (3) @(posedge clk_sys_i) #1;
		card_inserted_i = 1'b1;
		repeat (3) @(posedge clk_sys_i) #1;
		chk(native_disk_mode_o, 16'h0000);
		finish_test;
	end
endmodule
